// ===== logic/shc_engine.sv
// byte-wide spi transfer engine, host and client roles
`timescale 1ns/1ps
`default_nettype none

module shc_engine #(
    parameter int HALF_DIV = shc_pkg::SCK_HALF_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire shc_pkg::shc_cfg_t cfg,
    input wire logic role_wr,
    input wire logic role_wdata,
    input wire logic data_wr,
    input wire logic [7:0] data_wdata,
    input wire logic data_rd,
    input wire shc_pkg::shc_flags_t irq_enable,
    input wire shc_pkg::shc_flags_t flag_clr,
    output shc_pkg::shc_flags_t flags,
    output logic host_role,
    output logic [7:0] rd_data,
    output logic irq,
    input wire logic link_sck,
    output logic sck_o,
    output logic sck_oe,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    input wire logic ss_b_i
);

    localparam logic [7:0] DIV_LAST = 8'(HALF_DIV - 1);

    shc_pkg::shc_flags_t flags_r;
    shc_pkg::shc_flags_t set_v;
    shc_pkg::shc_flags_t clr_v;
    shc_pkg::shc_hst_t hst_state_r;
    logic host_r;
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [3:0] sync3_r;
    logic ss_s;
    logic miso_s;
    logic take_ev;
    logic done_ev;
    logic [7:0] hsh_r;
    logic [2:0] hbit_r;
    logic [7:0] div_r;
    logic sck_r;
    logic mosi_r;
    logic [7:0] txbuf_r;
    logic [7:0] cli_tx_r;
    logic armed_r;
    logic cli_busy_r;
    logic [7:0] rxq_r [2];
    logic [1:0] rxq_cnt_r;
    logic [7:0] rx_hold_r;
    logic [7:0] rd_data_r;
    logic comp_d1_r;
    logic comp_d2_r;
    logic [7:0] comp_byte_r;
    logic irq_r;
    logic miso_oe_r;
    // link domain
    logic link_rst_b;
    logic [2:0] rcnt_l;
    logic [7:0] tx_sh_l;
    logic miso_l;
    logic take_tgl_l;
    logic [2:0] fcnt_l;
    logic [7:0] rx_sh_l;
    logic [7:0] rx_l;
    logic done_tgl_l;
    // combinational terms
    logic buf_mode;
    logic dre;
    logic host_ss_drop;
    logic sck_tick;
    logic hst_done;
    logic hst_free;
    logic hst_wr;
    logic hst_reload;
    logic hst_start;
    logic hst_wcol;
    logic hst_tobuf;
    logic cli_wr;
    logic cli_wcol;
    logic cli_tobuf;
    logic cli_move;
    logic comp_ev;
    logic [7:0] comp_byte;
    logic rx_pop;
    logic rx_push;
    logic rx_full;
    logic [1:0] rx_idx;

    assign buf_mode = cfg.buffer_mode_enable;
    assign dre = flags_r.tx_buffer_empty_flag;
    assign ss_s = sync2_r[3];
    assign miso_s = sync2_r[2];
    assign take_ev = sync2_r[1] ^ sync3_r[1];
    assign done_ev = sync2_r[0] ^ sync3_r[0];

    // pins and link toggles cross into clk through two flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_r <= shc_pkg::SYNC_RST;
            sync2_r <= shc_pkg::SYNC_RST;
            sync3_r <= shc_pkg::SYNC_RST;
        end else begin
            sync1_r <= {ss_b_i, miso_i, take_tgl_l, done_tgl_l};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // select only counts as an input with the disable bit clear
    assign host_ss_drop = host_r & ~cfg.select_pin_disable
        & ~cfg.ss_is_output & ~ss_s;

    // host engine: sck rises to drive, falls to sample
    assign sck_tick = (hst_state_r == shc_pkg::HST_RUN)
        && (div_r == DIV_LAST);
    assign hst_done = sck_tick & sck_r & (hbit_r == shc_pkg::BIT_LAST);
    assign hst_free = (hst_state_r == shc_pkg::HST_IDLE) | hst_done;
    assign hst_wr = data_wr & host_r;
    // wait-for-receive is never looked at on the host path
    assign hst_reload = hst_done & buf_mode & ~dre;
    assign hst_start = host_r & ~host_ss_drop
        & ((hst_wr & hst_free & (~buf_mode | dre)) | hst_reload);
    assign hst_wcol = hst_wr & ~buf_mode & ~hst_free;
    assign hst_tobuf = hst_wr & buf_mode & dre & ~hst_free;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hst_state_r <= shc_pkg::HST_IDLE;
            hsh_r <= shc_pkg::BYTE_RST;
            hbit_r <= shc_pkg::BIT_FIRST;
            div_r <= shc_pkg::DIV_RST;
            sck_r <= 1'b0;
            mosi_r <= 1'b0;
        end else if (host_ss_drop | ~host_r) begin
            hst_state_r <= shc_pkg::HST_IDLE;
            hbit_r <= shc_pkg::BIT_FIRST;
            div_r <= shc_pkg::DIV_RST;
            sck_r <= 1'b0;
        end else if (hst_start) begin
            hst_state_r <= shc_pkg::HST_RUN;
            hsh_r <= hst_reload ? txbuf_r : data_wdata;
            hbit_r <= shc_pkg::BIT_FIRST;
            div_r <= shc_pkg::DIV_RST;
            sck_r <= 1'b0;
        end else if (hst_state_r == shc_pkg::HST_RUN) begin
            if (sck_tick) begin
                div_r <= shc_pkg::DIV_RST;
                sck_r <= ~sck_r;
                if (!sck_r) begin
                    mosi_r <= hsh_r[7];
                end else begin
                    hsh_r <= {hsh_r[6:0], miso_s};
                    hbit_r <= hbit_r + 3'h1;
                    hst_state_r <= (hbit_r == shc_pkg::BIT_LAST)
                        ? shc_pkg::HST_IDLE : shc_pkg::HST_RUN;
                end
            end else begin
                div_r <= div_r + 8'h01;
            end
            // early write lands in the live shifter on purpose
            if (hst_wcol) begin
                hsh_r <= data_wdata;
            end
        end
    end

    // host role bit: a select drop beats a software set
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            host_r <= 1'b0;
        end else if (host_ss_drop) begin
            host_r <= 1'b0;
        end else if (role_wr) begin
            host_r <= role_wdata;
        end
    end

    // client side, clk domain
    assign cli_wr = data_wr & ~host_r;
    assign cli_wcol = cli_wr & ~buf_mode & cli_busy_r;
    assign cli_tobuf = cli_wr & buf_mode & dre;
    assign cli_move = ~host_r & buf_mode & ~dre & (take_ev
        | (cfg.wait_for_receive_select & ss_s & ~armed_r));

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cli_busy_r <= 1'b0;
        end else if (ss_s | done_ev) begin
            cli_busy_r <= 1'b0;
        end else if (take_ev) begin
            cli_busy_r <= 1'b1;
        end
    end

    // armed word is what the link loads at the next first edge;
    // unarmed, the link resends the last byte it received as the dummy
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cli_tx_r <= shc_pkg::BYTE_RST;
            armed_r <= 1'b0;
        end else if (cli_move) begin
            cli_tx_r <= txbuf_r;
            armed_r <= 1'b1;
        end else if (cli_wr & ~buf_mode & ~cli_busy_r) begin
            cli_tx_r <= data_wdata;
            armed_r <= 1'b1;
        end else if (take_ev) begin
            armed_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            txbuf_r <= shc_pkg::BYTE_RST;
        end else if (hst_tobuf | cli_tobuf) begin
            txbuf_r <= data_wdata;
        end
    end

    // completion from either role, piped for the flag order
    assign comp_ev = host_r ? hst_done : done_ev;
    assign comp_byte = host_r ? {hsh_r[6:0], miso_s} : rx_l;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            comp_d1_r <= 1'b0;
            comp_d2_r <= 1'b0;
            comp_byte_r <= shc_pkg::BYTE_RST;
        end else begin
            comp_d1_r <= comp_ev;
            comp_d2_r <= comp_d1_r;
            if (comp_ev) begin
                comp_byte_r <= comp_byte;
            end
        end
    end

    // receive side: holding register or two-deep queue
    assign rx_full = (rxq_cnt_r == shc_pkg::RXQ_FULL);
    assign rx_pop = data_rd & buf_mode & (rxq_cnt_r != shc_pkg::RXQ_EMPTY);
    assign rx_push = comp_d1_r & buf_mode & (~rx_full | rx_pop);
    assign rx_idx = rx_pop ? rxq_cnt_r - 2'h1 : rxq_cnt_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rxq_r[0] <= shc_pkg::BYTE_RST;
            rxq_r[1] <= shc_pkg::BYTE_RST;
            rxq_cnt_r <= shc_pkg::RXQ_EMPTY;
        end else begin
            if (rx_pop) begin
                rxq_r[0] <= rxq_r[1];
            end
            if (rx_push) begin
                rxq_r[rx_idx[0]] <= comp_byte_r;
            end
            rxq_cnt_r <= rxq_cnt_r + {1'b0, rx_push} - {1'b0, rx_pop};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_hold_r <= shc_pkg::BYTE_RST;
            rd_data_r <= shc_pkg::BYTE_RST;
        end else begin
            // unread byte is simply overwritten
            if (comp_d1_r & ~buf_mode) begin
                rx_hold_r <= comp_byte_r;
            end
            rd_data_r <= buf_mode ? rxq_r[0] : rx_hold_r;
        end
    end

    // flags: set always beats a same-cycle clear
    always_comb begin
        set_v = '0;
        clr_v = flag_clr;
        set_v.transfer_done_flag = (comp_ev & ~buf_mode)
            | host_ss_drop;
        set_v.write_collision_flag = hst_wcol | cli_wcol;
        set_v.receive_complete_flag = comp_d1_r & buf_mode;
        set_v.transfer_complete_flag = comp_d2_r & buf_mode & dre
            & (host_r ? (hst_state_r == shc_pkg::HST_IDLE)
            : ~armed_r);
        set_v.rx_overflow_flag = comp_d1_r & buf_mode & rx_full
            & ~rx_pop;
        // empty flag is pure buffer state, software cannot clear it
        clr_v.tx_buffer_empty_flag = hst_tobuf | cli_tobuf;
        set_v.tx_buffer_empty_flag = hst_reload | cli_move;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_r <= shc_pkg::FLAGS_RST;
        end else begin
            flags_r <= (flags_r & ~clr_v) | set_v;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_r <= 1'b0;
            miso_oe_r <= 1'b0;
        end else begin
            irq_r <= |(flags_r & irq_enable);
            miso_oe_r <= ~host_r & cfg.miso_is_output & ~ss_s;
        end
    end

    // link domain: select high holds the bit logic in reset, so a
    // torn byte never completes; the raw pin is used since the
    // reset must act with no sck running
    assign link_rst_b = rst_b & ~ss_b_i;

    // cli_tx_r and armed_r change after a take event, on a write while
    // not busy, or on a select-high wait-for-receive move (needs slow sck)
    always_ff @(posedge link_sck or negedge link_rst_b) begin
        if (!link_rst_b) begin
            rcnt_l <= shc_pkg::BIT_FIRST;
            tx_sh_l <= shc_pkg::BYTE_RST;
            miso_l <= 1'b0;
        end else begin
            rcnt_l <= rcnt_l + 3'h1;
            if (rcnt_l == shc_pkg::BIT_FIRST) begin
                tx_sh_l <= armed_r ? {cli_tx_r[6:0], 1'b0}
                    : {rx_l[6:0], 1'b0};
                miso_l <= armed_r ? cli_tx_r[7] : rx_l[7];
            end else begin
                tx_sh_l <= {tx_sh_l[6:0], 1'b0};
                miso_l <= tx_sh_l[7];
            end
        end
    end

    always_ff @(posedge link_sck or negedge rst_b) begin
        if (!rst_b) begin
            take_tgl_l <= 1'b0;
        end else if (~ss_b_i && rcnt_l == shc_pkg::BIT_FIRST) begin
            take_tgl_l <= ~take_tgl_l;
        end
    end

    always_ff @(negedge link_sck or negedge link_rst_b) begin
        if (!link_rst_b) begin
            fcnt_l <= shc_pkg::BIT_FIRST;
            rx_sh_l <= shc_pkg::BYTE_RST;
        end else begin
            fcnt_l <= fcnt_l + 3'h1;
            rx_sh_l <= {rx_sh_l[6:0], mosi_i};
        end
    end

    // completed byte stays put for eight sck edges, ample to cross
    always_ff @(negedge link_sck or negedge rst_b) begin
        if (!rst_b) begin
            rx_l <= shc_pkg::BYTE_RST;
            done_tgl_l <= 1'b0;
        end else if (~ss_b_i && fcnt_l == shc_pkg::BIT_LAST) begin
            rx_l <= {rx_sh_l[6:0], mosi_i};
            done_tgl_l <= ~done_tgl_l;
        end
    end

    assign flags = flags_r;
    assign host_role = host_r;
    assign rd_data = rd_data_r;
    assign irq = irq_r;
    assign sck_o = sck_r;
    assign sck_oe = host_r;
    assign mosi_o = mosi_r;
    assign mosi_oe = host_r;
    assign miso_o = miso_l;
    assign miso_oe = miso_oe_r;

endmodule : shc_engine

`default_nettype wire

// ===== common/shc_pkg.sv
// shared types and constants for the spi host/client transfer engine
package shc_pkg;

    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [1:0] RXQ_FULL = 2'h2;
    localparam logic [1:0] RXQ_EMPTY = 2'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [7:0] DIV_RST = 8'h00;
    // reset image of {ss_b, miso, take toggle, done toggle}
    localparam logic [3:0] SYNC_RST = 4'h8;
    // sck half period in clk cycles while in host role
    localparam int SCK_HALF_CYC = 4;

    typedef enum logic {
        HST_IDLE,
        HST_RUN
    } shc_hst_t;

    typedef struct packed {
        logic transfer_done_flag;
        logic write_collision_flag;
        logic tx_buffer_empty_flag;
        logic transfer_complete_flag;
        logic receive_complete_flag;
        logic rx_overflow_flag;
    } shc_flags_t;

    // only the transmit buffer starts out empty
    localparam shc_flags_t FLAGS_RST = 6'h08;

    typedef struct packed {
        logic buffer_mode_enable;
        logic wait_for_receive_select;
        logic select_pin_disable;
        logic ss_is_output;
        logic miso_is_output;
    } shc_cfg_t;

endpackage : shc_pkg

// ===== test/shc_chk_assertions.sv
// port assertions for the spi transfer engine
`timescale 1ns/1ps
`default_nettype none
module shc_chk #(
    parameter int HALF_DIV = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire shc_pkg::shc_cfg_t cfg,
    input wire logic role_wr,
    input wire logic data_wr,
    input wire shc_pkg::shc_flags_t irq_enable,
    input wire shc_pkg::shc_flags_t flags,
    input wire logic host_role,
    input wire logic irq,
    input wire logic sck_o,
    input wire logic miso_oe,
    input wire logic ss_b_i
);
    localparam int START_MAX = HALF_DIV + 2;
    logic sck_q_r;
    logic [2:0] falls_r;
    logic sck_fall;
    assign sck_fall = sck_q_r & ~sck_o;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sck_q_r <= 1'b0;
        end else begin
            sck_q_r <= sck_o;
        end
    end
    // counts host sck falls; cleared when the role is lost mid byte
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            falls_r <= 3'h0;
        end else if (!host_role) begin
            falls_r <= 3'h0;
        end else if (sck_fall) begin
            falls_r <= falls_r + 3'h1;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_idle_wr;
        host_role && data_wr && !cfg.buffer_mode_enable && !sck_o
            && falls_r == 3'h0;
    endsequence
    sequence s_last_fall;
        host_role && !cfg.buffer_mode_enable && sck_fall
            && falls_r == 3'h7;
    endsequence
    property p_host_start;
        s_idle_wr |-> ##[1:START_MAX] sck_o;
    endproperty
    a_host_start: assert property (p_host_start)
        else $error("host write did not start sck");
    property p_host_done;
        s_last_fall |-> ##[0:3] flags.transfer_done_flag;
    endproperty
    a_host_done: assert property (p_host_done)
        else $error("done flag missing after eighth fall");
    property p_wcol;
        host_role && data_wr && !cfg.buffer_mode_enable && sck_o
            |-> ##[1:2] flags.write_collision_flag;
    endproperty
    a_wcol: assert property (p_wcol)
        else $error("busy host write left collision flag low");
    property p_ss_drop;
        host_role && !cfg.select_pin_disable && !cfg.ss_is_output
            && !ss_b_i |-> ##[1:4] (!host_role && flags.transfer_done_flag);
    endproperty
    a_ss_drop: assert property (p_ss_drop)
        else $error("low select did not end host role");
    property p_ss_keep;
        host_role && !role_wr
            && (cfg.select_pin_disable || cfg.ss_is_output) |=> host_role;
    endproperty
    a_ss_keep: assert property (p_ss_keep)
        else $error("host role lost while select pin ignored");
    property p_irq;
        1'b1 |=> (irq == $past(|(flags & irq_enable)));
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq differs from enabled flags");
    property p_txe_fall;
        !host_role && cfg.buffer_mode_enable && data_wr
            && flags.tx_buffer_empty_flag |=> !flags.tx_buffer_empty_flag;
    endproperty
    a_txe_fall: assert property (p_txe_fall)
        else $error("buffer empty flag did not fall on write");
    property p_miso_off;
        // select crosses two flops and the enable flop behind them
        ss_b_i && $past(ss_b_i) && $past(ss_b_i, 2) && $past(ss_b_i, 3)
            |-> !miso_oe;
    endproperty
    a_miso_off: assert property (p_miso_off)
        else $error("miso driven while deselected");
endmodule : shc_chk
bind shc_engine shc_chk #(.HALF_DIV(HALF_DIV)) i_chk (
    .clk(clk), .rst_b(rst_b), .cfg(cfg), .role_wr(role_wr),
    .data_wr(data_wr), .irq_enable(irq_enable), .flags(flags),
    .host_role(host_role), .irq(irq), .sck_o(sck_o),
    .miso_oe(miso_oe), .ss_b_i(ss_b_i)
);
`default_nettype wire

// ===== test/shc_far_end.sv
// far side of the link: echoing client or external host
`timescale 1ns/1ps
`default_nettype none
module shc_far_end (
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    output logic far_sck,
    output logic far_mosi,
    output logic far_miso,
    output logic far_ss_b
);
    logic [7:0] sreg;
    logic hosting;
    int nfall;
    initial begin
        sreg = 8'h00;
        hosting = 1'b0;
        nfall = 0;
        far_sck = 1'b0;
        far_mosi = 1'b0;
        far_miso = 1'b0;
        far_ss_b = 1'b1;
    end
    // client: out on rise, in on fall; line flips once the byte is over
    always @(posedge sck) begin
        if (!hosting) far_miso <= sreg[7];
    end
    always @(negedge sck) begin
        if (!hosting) begin
            sreg <= {sreg[6:0], mosi};
            nfall = (nfall + 1) % 8;
            if (nfall == 0) far_miso <= ~far_miso;
        end
    end
    // host: sck only inside frames, halves of three clk cycles, above two
    task automatic xfer(input logic [7:0] tx, input int nbits,
                        output logic [7:0] rx);
        rx = 8'h00;
        hosting = 1'b1;
        far_ss_b = 1'b0;
        #29;
        for (int i = 0; i < nbits; i++) begin
            far_sck = 1'b1;
            far_mosi = tx[7 - i];
            #24;
            far_sck = 1'b0;
            rx = {rx[6:0], miso};
            #24;
        end
        #40;
        far_ss_b = 1'b1;
        far_mosi = ~far_mosi;
        hosting = 1'b0;
        // select stays high between frames so the client can reset
        #48;
    endtask : xfer
endmodule : shc_far_end
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the spi transfer engine
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // the two-flop miso path needs half periods above two clks
    localparam int HD = 4;
    logic clk, rst_b, role_wr, role_wdata, data_wr, data_rd;
    shc_pkg::shc_cfg_t cfg;
    shc_pkg::shc_flags_t irq_enable, flag_clr, flags;
    logic [7:0] data_wdata, rd_data, got;
    logic host_role, irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    logic far_sck, far_mosi, far_miso, far_ss_b, sck_p, mosi_p, miso_p;
    int fails, n_compared;
    assign sck_p = sck_oe ? sck_o : far_sck;
    assign mosi_p = mosi_oe ? mosi_o : far_mosi;
    assign miso_p = miso_oe ? miso_o : far_miso;
    shc_engine #(.HALF_DIV(HD)) i_dut (
        .clk(clk), .rst_b(rst_b), .cfg(cfg), .role_wr(role_wr),
        .role_wdata(role_wdata), .data_wr(data_wr),
        .data_wdata(data_wdata), .data_rd(data_rd),
        .irq_enable(irq_enable), .flag_clr(flag_clr), .flags(flags),
        .host_role(host_role), .rd_data(rd_data), .irq(irq),
        .link_sck(sck_p), .sck_o(sck_o), .sck_oe(sck_oe),
        .mosi_i(mosi_p), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
        .miso_i(miso_p), .miso_o(miso_o), .miso_oe(miso_oe),
        .ss_b_i(far_ss_b)
    );
    shc_far_end i_far (
        .sck(sck_p), .mosi(mosi_p), .miso(miso_p), .far_sck(far_sck),
        .far_mosi(far_mosi), .far_miso(far_miso), .far_ss_b(far_ss_b)
    );
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] seen);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic wr(input logic [7:0] d);
        data_wdata = d;
        data_wr = 1'b1;
        tick(1);
        data_wr = 1'b0;
    endtask : wr
    task automatic rd;
        data_rd = 1'b1;
        tick(1);
        data_rd = 1'b0;
        tick(2);
    endtask : rd
    task automatic role(input logic v);
        role_wdata = v;
        role_wr = 1'b1;
        tick(1);
        role_wr = 1'b0;
    endtask : role
    task automatic clr;
        flag_clr = '1;
        tick(1);
        flag_clr = '0;
    endtask : clr
    // bounded wait on one flag bit, then a settle for rd_data
    task automatic wait_flag(input int idx);
        int k;
        for (k = 0; k < 400 && flags[idx] !== 1'b1; k++) tick(1);
        chk("flag wait", 8'h01, 8'(flags[idx]));
        tick(2);
    endtask : wait_flag
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    task automatic t_host;
        i_far.sreg = 8'h3C;
        irq_enable.transfer_done_flag = 1'b1;
        role(1'b1);
        wr(8'hA5);
        wait_flag(5);
        chk("host rx", 8'h3C, rd_data);
        chk("far rx", 8'hA5, i_far.sreg);
        chk("irq on", 8'h01, 8'(irq));
        clr();
        tick(2);
        chk("irq off", 8'h00, 8'(irq));
        wr(8'h5A);
        tick(3);
        wr(8'hFF);
        wait_flag(5);
        chk("host wcol", 8'h01, 8'(flags.write_collision_flag));
        clr();
    endtask : t_host
    task automatic t_ss;
        cfg.select_pin_disable = 1'b1;
        i_far.far_ss_b = 1'b0;
        tick(8);
        chk("role ssd", 8'h01, 8'(host_role));
        cfg.select_pin_disable = 1'b0;
        cfg.ss_is_output = 1'b1;
        tick(8);
        chk("role ss out", 8'h01, 8'(host_role));
        cfg.ss_is_output = 1'b0;
        tick(6);
        chk("role ss low", 8'h00, 8'(host_role));
        chk("done ss low", 8'h01, 8'(flags.transfer_done_flag));
        i_far.far_ss_b = 1'b1;
        tick(2);
        clr();
    endtask : t_ss
    task automatic t_client;
        wr(8'hC3);
        tick(4);
        i_far.xfer(8'h96, 8, got);
        wait_flag(5);
        chk("cli out", 8'hC3, got);
        chk("cli rx", 8'h96, rd_data);
        clr();
        i_far.xfer(8'hF0, 4, got);
        tick(6);
        chk("no done", 8'h00, 8'(flags.transfer_done_flag));
        i_far.xfer(8'h69, 8, got);
        wait_flag(5);
        chk("after abort", 8'h69, rd_data);
        clr();
        wr(8'h3E);
        fork
            i_far.xfer(8'h11, 8, got);
            begin
                tick(20);
                wr(8'h7E);
            end
        join
        wait_flag(5);
        chk("cli wcol", 8'h01, 8'(flags.write_collision_flag));
        chk("cli kept", 8'h3E, got);
        clr();
    endtask : t_client
    task automatic t_buf;
        cfg.buffer_mode_enable = 1'b1;
        wr(8'h5A);
        chk("txe fall", 8'h00, 8'(flags.tx_buffer_empty_flag));
        i_far.xfer(8'h22, 8, got);
        chk("dummy", 8'h11, got);
        i_far.xfer(8'h33, 8, got);
        chk("cli buf", 8'h5A, got);
        tick(4);
        chk("txe rise", 8'h01, 8'(flags.tx_buffer_empty_flag));
        chk("q head", 8'h22, rd_data);
        rd();
        chk("q next", 8'h33, rd_data);
        rd();
        clr();
        cfg.wait_for_receive_select = 1'b1;
        role(1'b1);
        i_far.sreg = 8'h77;
        wr(8'h12);
        wait_flag(3);
        wr(8'h34);
        wait_flag(2);
        chk("far got", 8'h34, i_far.sreg);
        chk("hq head", 8'h77, rd_data);
        rd();
        chk("hq next", 8'h12, rd_data);
    endtask : t_buf
    task automatic t_wfr;
        role(1'b0);
        wr(8'hA1);
        tick(2);
        wr(8'hB2);
        wr(8'hC4);
        chk("txe full", 8'h00, 8'(flags.tx_buffer_empty_flag));
        i_far.xfer(8'hD1, 8, got);
        chk("wfr first", 8'hA1, got);
        i_far.xfer(8'hD2, 8, got);
        chk("wfr next", 8'hB2, got);
        wait_flag(0);
        rd();
        chk("ovf kept", 8'hD1, rd_data);
    endtask : t_wfr
    initial begin
        fails = 0;
        n_compared = 0;
        rst_b = 1'b0;
        cfg = '0;
        cfg.miso_is_output = 1'b1;
        {role_wr, role_wdata, data_wr, data_rd} = 4'h0;
        data_wdata = 8'h00;
        irq_enable = '0;
        flag_clr = '0;
        tick(4);
        rst_b = 1'b1;
        tick(3);
        chk("flags rst", {2'b00, shc_pkg::FLAGS_RST}, {2'b00, flags});
        chk("role rst", 8'h00, 8'(host_role));
        t_host();
        t_ss();
        t_client();
        t_buf();
        t_wfr();
        give_verdict();
    end
    // whole run needs well under 400 us
    initial begin
        #400000;
        fails++;
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
